// ---- core/ectim_top.sv ----
// Function
// - Eight-bit up-counter, two count read registers
// - Shadow count read never clears overflow
// - Writing either count register reloads FCh
// - Reset and only reload value FCh
// - Rate: cpu/2, /4, /8 or osc/8000
// - Rollover FFh to 00h sets overflow flag
// - Overflow irq needs flag, enable, clear mask
// - Overflow cleared by flag read, main access
// - Runs in wait, freezes in halt
// - Active edge copies count to capture register
// - Per-channel edge select bits choose edge
// - Capture sets flag, shared capture irq enable
// - Capture flag cleared by read-then-access sequence
// - Capture pin two always connected to timer, pin one not in waveform modes
// - Waveform modes leave only capture two
// - Compare each channel, set flag, irq
// - Compare registers software only, reset 00h
// - Match drives level to enabled pin
// - Disabled pin ignores match, flag still set
// - Match at value, or value+1 unless /2
// - Compare flag cleared by read-then-access sequence
// - Force copies level, no flag, not waveform
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ectim_consts.svh"

module ectim_top #(
    parameter int OSC_DIV = `ECTIM_OSC_DIV
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic halt,
    input wire logic global_irq_mask,
    input wire logic oscillator_clock_two,
    input wire logic [1:0] capture_pin,
    output logic [1:0] compare_out_pin,
    output logic [1:0] compare_out_en,
    output logic overflow_irq,
    output logic capture_irq,
    output logic compare_irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Word decode of a byte address against a register offset
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
        is_reg = (a[7:2] == o[7:2]);
    endfunction

    logic [7:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [7:0] rdata_reg;
    logic [7:0] ctrl_two_reg;
    logic [7:0] ctrl_one_reg;
    logic [7:0] count_reg;
    logic [7:0] cmp_val_reg [2];
    logic [7:0] cap_val_reg [2];
    logic [4:0] flag_reg;
    logic [4:0] arm_reg;
    logic [2:0] presc_reg;
    logic [12:0] osc_cnt_reg;
    logic [2:0] osc_sync_reg;
    logic [1:0] cap_s1_reg;
    logic [1:0] cap_s2_reg;
    logic [1:0] cap_s3_reg;
    logic [1:0] match_prev_reg;
    logic [1:0] pin_reg;
    logic ovf_irq_reg;
    logic cap_irq_reg;
    logic cmp_irq_reg;

    // Bus strobes
    wire aw_take = clk_en & s_axi_awvalid & awready_reg;
    wire w_take = clk_en & s_axi_wvalid & wready_reg;
    wire wr_fire = clk_en & aw_full_reg & w_full_reg & ~bvalid_reg;
    wire wr_en = wr_fire & wstrb0_reg;
    wire rd_fire = clk_en & s_axi_arvalid & arready_reg;

    // Write address decode
    wire wr_c2 = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_CTRL_TWO);
    wire wr_c1 = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_CTRL_ONE);
    wire wr_cap1 = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_CAP_ONE);
    wire wr_cmp1 = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_CMP_ONE);
    wire wr_main = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_MAIN_CNT);
    wire wr_shadow = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_SHADOW_CNT);
    wire wr_cap2 = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_CAP_TWO);
    wire wr_cmp2 = wr_en & is_reg(awaddr_reg, `ECTIM_OFF_CMP_TWO);
    wire wr_hit = is_reg(awaddr_reg, `ECTIM_OFF_CTRL_TWO)
        | is_reg(awaddr_reg, `ECTIM_OFF_CTRL_ONE)
        | is_reg(awaddr_reg, `ECTIM_OFF_FLAGS)
        | is_reg(awaddr_reg, `ECTIM_OFF_CAP_ONE)
        | is_reg(awaddr_reg, `ECTIM_OFF_CMP_ONE)
        | is_reg(awaddr_reg, `ECTIM_OFF_MAIN_CNT)
        | is_reg(awaddr_reg, `ECTIM_OFF_SHADOW_CNT)
        | is_reg(awaddr_reg, `ECTIM_OFF_CAP_TWO)
        | is_reg(awaddr_reg, `ECTIM_OFF_CMP_TWO);

    // Read address decode
    wire rd_c2 = is_reg(s_axi_araddr, `ECTIM_OFF_CTRL_TWO);
    wire rd_c1 = is_reg(s_axi_araddr, `ECTIM_OFF_CTRL_ONE);
    wire rd_sr = is_reg(s_axi_araddr, `ECTIM_OFF_FLAGS);
    wire rd_cap1 = is_reg(s_axi_araddr, `ECTIM_OFF_CAP_ONE);
    wire rd_cmp1 = is_reg(s_axi_araddr, `ECTIM_OFF_CMP_ONE);
    wire rd_main = is_reg(s_axi_araddr, `ECTIM_OFF_MAIN_CNT);
    wire rd_shadow = is_reg(s_axi_araddr, `ECTIM_OFF_SHADOW_CNT);
    wire rd_cap2 = is_reg(s_axi_araddr, `ECTIM_OFF_CAP_TWO);
    wire rd_cmp2 = is_reg(s_axi_araddr, `ECTIM_OFF_CMP_TWO);
    wire rd_hit = rd_c2 | rd_c1 | rd_sr | rd_cap1 | rd_cmp1 | rd_main
        | rd_shadow | rd_cap2 | rd_cmp2;

    // Read data selection; both count registers show the live count
    wire [7:0] rd_mux = ({8{rd_c2}} & ctrl_two_reg)
        | ({8{rd_c1}} & ctrl_one_reg)
        | ({8{rd_sr}} & {flag_reg, 3'h0})
        | ({8{rd_cap1}} & cap_val_reg[0])
        | ({8{rd_cmp1}} & cmp_val_reg[0])
        | ({8{rd_main | rd_shadow}} & count_reg)
        | ({8{rd_cap2}} & cap_val_reg[1])
        | ({8{rd_cmp2}} & cmp_val_reg[1]);

    // Control fields
    wire [1:0] pin_en = {ctrl_two_reg[`ECTIM_C2_PIN_EN2],
        ctrl_two_reg[`ECTIM_C2_PIN_EN1]};
    wire wave_mode = ctrl_two_reg[`ECTIM_C2_PULSE]
        | ctrl_two_reg[`ECTIM_C2_PWM];
    wire [1:0] clk_code = ctrl_two_reg[`ECTIM_C2_CLK_HI:`ECTIM_C2_CLK_LO];
    wire [1:0] level = {ctrl_one_reg[`ECTIM_C1_LEVEL2],
        ctrl_one_reg[`ECTIM_C1_LEVEL1]};
    wire [1:0] edge_sel = {ctrl_two_reg[`ECTIM_C2_EDGE2],
        ctrl_one_reg[`ECTIM_C1_EDGE1]};
    wire div2 = (clk_code == ectim_pkg::ECTIM_CLK_DIV2);

    // Prescaler tick selection
    wire run = clk_en & ~halt;
    wire cnt_load = wr_main | wr_shadow;
    wire osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];
    wire osc_wrap = osc_rise & (osc_cnt_reg == 13'(OSC_DIV - 1));
    wire cpu_tick = (clk_code == ectim_pkg::ECTIM_CLK_DIV2) ? presc_reg[0]
        : (clk_code == ectim_pkg::ECTIM_CLK_DIV4) ? (&presc_reg[1:0])
        : (&presc_reg);
    wire tick = run & ~cnt_load
        & ((clk_code == ectim_pkg::ECTIM_CLK_OSC) ? osc_wrap : cpu_tick);
    wire ovf_set = tick & (count_reg == `ECTIM_CNT_TOP);

    // Compare match, one count late except at divide by two
    logic [1:0] match;
    logic [1:0] cmp_hit;
    logic [1:0] cap_edge;
    logic [1:0] cap_event;
    logic [1:0] force_hit;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            wire [7:0] target = div2 ? cmp_val_reg[g]
                : 8'(cmp_val_reg[g] + 8'h01);
            assign match[g] = clk_en & (count_reg == target);
            assign cmp_hit[g] = match[g] & ~match_prev_reg[g];
            assign cap_edge[g] = edge_sel[g]
                ? (cap_s2_reg[g] & ~cap_s3_reg[g])
                : (~cap_s2_reg[g] & cap_s3_reg[g]);
        end
    endgenerate
    assign cap_event = {2{clk_en}}
        & {cap_edge[1], cap_edge[0] & ~wave_mode};
    assign force_hit = {2{wr_c1 & ~wave_mode}}
        & {wdata_reg[`ECTIM_C1_FORCE2], wdata_reg[`ECTIM_C1_FORCE1]};
    wire [1:0] new_level = {wdata_reg[`ECTIM_C1_LEVEL2],
        wdata_reg[`ECTIM_C1_LEVEL1]};

    // Flag set, access and clear vectors
    wire [4:0] flag_set = {cap_event[0], cmp_hit[0], ovf_set, cap_event[1],
        cmp_hit[1]};
    wire [4:0] flag_acc = {wr_cap1 | (rd_fire & rd_cap1),
        wr_cmp1 | (rd_fire & rd_cmp1),
        wr_main | (rd_fire & rd_main),
        wr_cap2 | (rd_fire & rd_cap2),
        wr_cmp2 | (rd_fire & rd_cmp2)};
    wire [4:0] flag_clr = arm_reg & flag_acc;
    wire [4:0] flag_next = flag_set | (flag_reg & ~flag_clr);
    wire [4:0] arm_next = ({5{rd_fire & rd_sr}} & flag_reg)
        | (arm_reg & ~flag_clr);

    // Interrupt request levels, pending while masked
    wire ovf_irq_next = flag_reg[`ECTIM_F_OVF]
        & ctrl_one_reg[`ECTIM_C1_OVF_IE] & ~global_irq_mask;
    wire cap_irq_next = (flag_reg[`ECTIM_F_CAP1] | flag_reg[`ECTIM_F_CAP2])
        & ctrl_one_reg[`ECTIM_C1_CAP_IE] & ~global_irq_mask;
    wire cmp_irq_next = (flag_reg[`ECTIM_F_CMP1] | flag_reg[`ECTIM_F_CMP2])
        & ctrl_one_reg[`ECTIM_C1_CMP_IE] & ~global_irq_mask;

    // Pin latch next value
    logic [1:0] pin_next;
    always_comb begin
        pin_next = pin_reg;
        for (int i = 0; i < 2; i++) begin
            if (cmp_hit[i] & pin_en[i]) begin
                pin_next[i] = level[i];
            end else if (force_hit[i] & pin_en[i]) begin
                pin_next[i] = new_level[i];
            end
        end
    end

    // Write channel holding and response
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ECTIM_RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `ECTIM_RESP_OKAY : `ECTIM_RESP_SLVERR;
            end
            if (bvalid_reg & s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= `ECTIM_RESP_OKAY;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            if (rd_fire) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? `ECTIM_RESP_OKAY : `ECTIM_RESP_SLVERR;
            end else if (rvalid_reg & s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // Control and compare value registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_two_reg <= `ECTIM_CTRL_RESET;
            ctrl_one_reg <= `ECTIM_CTRL_RESET;
            cmp_val_reg[0] <= `ECTIM_CMP_RESET;
            cmp_val_reg[1] <= `ECTIM_CMP_RESET;
        end else if (clk_en) begin
            if (wr_c2) ctrl_two_reg <= wdata_reg & `ECTIM_C2_WMASK;
            if (wr_c1) ctrl_one_reg <= wdata_reg & `ECTIM_C1_WMASK;
            if (wr_cmp1) cmp_val_reg[0] <= wdata_reg;
            if (wr_cmp2) cmp_val_reg[1] <= wdata_reg;
        end
    end

    // Prescaler and free-running counter
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            presc_reg <= 3'h0;
            osc_cnt_reg <= 13'h0000;
            count_reg <= `ECTIM_CNT_RELOAD;
        end else if (clk_en) begin
            if (cnt_load) begin
                presc_reg <= 3'h0;
                osc_cnt_reg <= 13'h0000;
                count_reg <= `ECTIM_CNT_RELOAD;
            end else if (run) begin
                presc_reg <= 3'(presc_reg + 3'h1);
                if (osc_rise) begin
                    osc_cnt_reg <= osc_wrap ? 13'h0000
                        : 13'(osc_cnt_reg + 13'h0001);
                end
                if (tick) count_reg <= 8'(count_reg + 8'h01);
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            osc_sync_reg <= 3'h0;
            cap_s1_reg <= 2'h0;
            cap_s2_reg <= 2'h0;
            cap_s3_reg <= 2'h0;
        end else if (clk_en) begin
            osc_sync_reg <= {osc_sync_reg[1:0], oscillator_clock_two};
            cap_s1_reg <= capture_pin;
            cap_s2_reg <= cap_s1_reg;
            cap_s3_reg <= cap_s2_reg;
        end
    end

    // Capture registers hold the latest capture
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cap_val_reg[0] <= 8'h00;
            cap_val_reg[1] <= 8'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_event[i]) cap_val_reg[i] <= count_reg;
            end
        end
    end

    // Flags, clear sequence arming, pins and interrupts
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flag_reg <= 5'h00;
            arm_reg <= 5'h00;
            match_prev_reg <= 2'h0;
            pin_reg <= 2'h0;
            ovf_irq_reg <= 1'b0;
            cap_irq_reg <= 1'b0;
            cmp_irq_reg <= 1'b0;
        end else if (clk_en) begin
            flag_reg <= flag_next;
            arm_reg <= arm_next;
            match_prev_reg <= match;
            pin_reg <= pin_next;
            ovf_irq_reg <= ovf_irq_next;
            cap_irq_reg <= cap_irq_next;
            cmp_irq_reg <= cmp_irq_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};
    assign compare_out_pin = pin_reg;
    assign compare_out_en = pin_en;
    assign overflow_irq = ovf_irq_reg;
    assign capture_irq = cap_irq_reg;
    assign compare_irq = cmp_irq_reg;

    // Clear sequence steps
    sequence s_ovf_armed;
        arm_reg[`ECTIM_F_OVF] && flag_reg[`ECTIM_F_OVF];
    endsequence
    sequence s_main_access;
        flag_acc[`ECTIM_F_OVF] && !ovf_set;
    endsequence

    a_count_reload: assert property (cnt_load
        |=> count_reg == `ECTIM_CNT_RELOAD)
        else $error("count not reloaded after count write");
    a_ovf_set: assert property (ovf_set |=> flag_reg[`ECTIM_F_OVF]
        && count_reg == 8'h00)
        else $error("rollover did not set overflow flag");
    a_ovf_clear: assert property (s_ovf_armed ##0 s_main_access
        |=> !flag_reg[`ECTIM_F_OVF])
        else $error("overflow flag survived clear sequence");
    a_shadow_keep: assert property (flag_reg[`ECTIM_F_OVF]
        && rd_fire && rd_shadow |=> flag_reg[`ECTIM_F_OVF])
        else $error("shadow read cleared overflow flag");
    a_ovf_irq: assert property (clk_en |=> overflow_irq ==
        $past(flag_reg[`ECTIM_F_OVF] && ctrl_one_reg[`ECTIM_C1_OVF_IE]
        && !global_irq_mask))
        else $error("overflow irq does not follow its terms");
    a_halt_freeze: assert property (halt && !cnt_load
        |=> $stable(count_reg))
        else $error("counter moved during halt");
    a_cap_load: assert property (cap_event[1]
        |=> cap_val_reg[1] == $past(count_reg))
        else $error("capture two missed the count");
    a_cap_wave: assert property (wave_mode |-> !cap_event[0])
        else $error("capture one active in waveform mode");
    a_cmp_late: assert property (cmp_hit[1] && !div2
        |-> count_reg == 8'(cmp_val_reg[1] + 8'h01))
        else $error("compare two matched at wrong count");
    a_cmp_pin: assert property (cmp_hit[0] && pin_en[0]
        |=> compare_out_pin[0] == $past(level[0]))
        else $error("compare one pin missed its level");
    a_force_noflag: assert property (force_hit[0] && !cmp_hit[0]
        && !flag_reg[`ECTIM_F_CMP1] |=> !flag_reg[`ECTIM_F_CMP1])
        else $error("force set the compare flag");

endmodule // ectim_top

`default_nettype wire

// ---- core/ectim_consts.svh ----
`ifndef ECTIM_CONSTS_SVH
`define ECTIM_CONSTS_SVH

// Register byte offsets
`define ECTIM_OFF_CTRL_TWO 8'h00
`define ECTIM_OFF_CTRL_ONE 8'h04
`define ECTIM_OFF_FLAGS 8'h08
`define ECTIM_OFF_CAP_ONE 8'h0C
`define ECTIM_OFF_CMP_ONE 8'h10
`define ECTIM_OFF_MAIN_CNT 8'h14
`define ECTIM_OFF_SHADOW_CNT 8'h18
`define ECTIM_OFF_CAP_TWO 8'h1C
`define ECTIM_OFF_CMP_TWO 8'h20

// Control register two fields
`define ECTIM_C2_PIN_EN1 7
`define ECTIM_C2_PIN_EN2 6
`define ECTIM_C2_PULSE 5
`define ECTIM_C2_PWM 4
`define ECTIM_C2_CLK_HI 3
`define ECTIM_C2_CLK_LO 2
`define ECTIM_C2_EDGE2 1
`define ECTIM_C2_WMASK 8'hFE

// Control register one fields
`define ECTIM_C1_CAP_IE 7
`define ECTIM_C1_CMP_IE 6
`define ECTIM_C1_OVF_IE 5
`define ECTIM_C1_FORCE2 4
`define ECTIM_C1_FORCE1 3
`define ECTIM_C1_LEVEL2 2
`define ECTIM_C1_EDGE1 1
`define ECTIM_C1_LEVEL1 0
`define ECTIM_C1_WMASK 8'hE7

// Flag vector positions, flag register bits 7..3
`define ECTIM_F_CMP2 0
`define ECTIM_F_CAP2 1
`define ECTIM_F_OVF 2
`define ECTIM_F_CMP1 3
`define ECTIM_F_CAP1 4

// Reset and reload values
`define ECTIM_CNT_RELOAD 8'hFC
`define ECTIM_CNT_TOP 8'hFF
`define ECTIM_CMP_RESET 8'h00
`define ECTIM_CTRL_RESET 8'h00
`define ECTIM_OSC_DIV 8000

// Bus responses
`define ECTIM_RESP_OKAY 2'h0
`define ECTIM_RESP_SLVERR 2'h2

`endif

// ---- core/ectim_pkg.sv ----
package ectim_pkg;
    // Counting rate codes of the clock select field
    typedef enum logic [1:0] {
        ECTIM_CLK_DIV2 = 2'h0,
        ECTIM_CLK_DIV4 = 2'h1,
        ECTIM_CLK_DIV8 = 2'h2,
        ECTIM_CLK_OSC = 2'h3
    } ectim_clk_type;
endpackage : ectim_pkg

// ---- bench/ectim_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ectim_pins_model (
    input wire logic mclk,
    input wire logic [1:0] level_req,
    input wire logic [1:0] compare_out_pin,
    input wire logic [1:0] compare_out_en,
    output logic [1:0] capture_pin,
    output logic [1:0] pad_level
);
    // Released compare pads float up through their pull-ups
    assign pad_level = (compare_out_en & compare_out_pin) | ~compare_out_en;

    // Capture lines follow the commanded level just after an edge
    always @(posedge mclk) begin
        capture_pin <= level_req;
    end
endmodule // ectim_pins_model

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [7:0] d;
        logic [1:0] r;
    } ectim_tb_row_type;
    logic mclk, reset, clk_en, halt, irq_mask, osc;
    logic [1:0] cap_req, cap_pin, cmp_pin, cmp_en, pad, bresp, rresp, rs;
    logic ovf_irq, cap_irq, cmp_irq, ap, wp, ta, tw;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    int failures, tests_run, n;
    ectim_tb_row_type rows [10] = '{
        {8'h10, 1'b0, 8'h00, 2'h0}, {8'h20, 1'b0, 8'h00, 2'h0},
        {8'h14, 1'b0, 8'hFC, 2'h0}, {8'h18, 1'b0, 8'hFC, 2'h0},
        {8'h00, 1'b0, 8'h00, 2'h0}, {8'h10, 1'b1, 8'h5A, 2'h0},
        {8'h10, 1'b0, 8'h5A, 2'h0}, {8'h20, 1'b1, 8'hA5, 2'h0},
        {8'h20, 1'b0, 8'hA5, 2'h0}, {8'h24, 1'b0, 8'h00, 2'h2}};

    ectim_top #(.OSC_DIV(4)) i_ectim_top (
        .mclk(mclk), .reset(reset), .clk_en(clk_en), .halt(halt),
        .global_irq_mask(irq_mask), .oscillator_clock_two(osc),
        .capture_pin(cap_pin), .compare_out_pin(cmp_pin),
        .compare_out_en(cmp_en), .overflow_irq(ovf_irq),
        .capture_irq(cap_irq), .compare_irq(cmp_irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1));

    ectim_pins_model i_ectim_pins_model (
        .mclk(mclk), .level_req(cap_req), .compare_out_pin(cmp_pin),
        .compare_out_en(cmp_en), .capture_pin(cap_pin), .pad_level(pad));

    // Bus clock and a slow unrelated oscillator
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        osc = 1'b0;
        forever #130 osc = ~osc;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        ap = 1'b1;
        wp = 1'b1;
        while (ap | wp) begin
            @(negedge mclk);
            ta = ap & awready;
            tw = wp & wready;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            ap = ap & ~ta;
            wp = wp & ~tw;
        end
        do @(negedge mclk); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge mclk);
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge mclk); while (arready !== 1'b1);
        @(posedge mclk);
        arvalid <= 1'b0;
        do @(negedge mclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        @(posedge mclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        rdr(a);
        chk(rd & {24'h0, m}, {24'h0, e});
    endtask

    task automatic results();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #400000;
        failures++;
        results();
    end

    // Main sequence
    initial begin
        {reset, halt, irq_mask, clk_en} = 4'hF;
        {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
        cap_req = 2'h3;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        chk({30'h0, cmp_pin}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rdr(rows[i].a);
            if (!rows[i].w) chk(rd, {24'h0, rows[i].d});
            chk({30'h0, rs}, {30'h0, rows[i].r});
        end
        $display("register table done");
        // Overflow held back by the mask, then released
        wr(8'h04, 8'h20);
        halt <= 1'b0;
        repeat (40) @(posedge mclk);
        chk({31'h0, ovf_irq}, 32'h0);
        irq_mask <= 1'b0;
        repeat (3) @(negedge mclk);
        chk({31'h0, ovf_irq}, 32'h1);
        rchk(8'h08, 8'h20, 8'h20);
        rdr(8'h18);
        rchk(8'h08, 8'h20, 8'h20);
        rdr(8'h14);
        rchk(8'h08, 8'h20, 8'h00);
        halt <= 1'b1;
        wr(8'h18, 8'h33);
        rchk(8'h14, 8'hFF, 8'hFC);
        repeat (20) @(posedge mclk);
        rchk(8'h14, 8'hFF, 8'hFC);
        $display("overflow done");
        // Channel two on falling, channel one on rising edges
        wr(8'h04, 8'h82);
        wr(8'h00, 8'h00);
        cap_req <= 2'h1;
        repeat (6) @(posedge mclk);
        rchk(8'h08, 8'h90, 8'h10);
        chk({31'h0, cap_irq}, 32'h1);
        rchk(8'h1C, 8'hFF, 8'hFC);
        rchk(8'h08, 8'h10, 8'h00);
        cap_req <= 2'h2;
        repeat (6) @(posedge mclk);
        rchk(8'h08, 8'h90, 8'h00);
        cap_req <= 2'h3;
        repeat (6) @(posedge mclk);
        rchk(8'h08, 8'h90, 8'h80);
        rchk(8'h0C, 8'hFF, 8'hFC);
        wr(8'h00, 8'h20);
        cap_req <= 2'h2;
        repeat (6) @(posedge mclk);
        cap_req <= 2'h3;
        repeat (6) @(posedge mclk);
        rchk(8'h08, 8'h80, 8'h00);
        $display("capture done");
        // Match point at divide-by-2 versus divide-by-4 and divide-by-8
        wr(8'h10, 8'hFE);
        wr(8'h20, 8'hFE);
        for (int i = 0; i < 3; i++) begin
            halt <= 1'b1;
            wr(8'h14, 8'h00);
            wr(8'h00, {4'h8, 2'(i), 2'h0});
            wr(8'h04, 8'h48);
            chk({31'h0, pad[0]}, 32'h0);
            wr(8'h04, 8'h45);
            rdr(8'h08);
            rchk(8'h10, 8'hFF, 8'hFE);
            rchk(8'h08, 8'h40, 8'h00);
            halt <= 1'b0;
            n = 0;
            while (pad[0] !== 1'b1 && n < 40) begin
                @(negedge mclk);
                n++;
            end
            chk(i == 0 ? n <= 7 : i == 1 ? n >= 11 && n <= 18
                : n >= 22 && n <= 30, 32'h1);
            chk({30'h0, cmp_pin[1], pad[1]}, 32'h1);
            repeat (2) @(negedge mclk);
            chk({31'h0, cmp_irq}, 32'h1);
            rchk(8'h08, 8'h48, 8'h48);
        end
        $display("compare done");
        // Oscillator rate: four slow edges per count
        halt <= 1'b1;
        wr(8'h00, 8'h0C);
        wr(8'h14, 8'h00);
        halt <= 1'b0;
        repeat (70) @(posedge mclk);
        halt <= 1'b1;
        rchk(8'h18, 8'hFE, 8'hFE);
        $display("oscillator done");
        // Reset in mid-run restores reload count and compare one value
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        chk({29'h0, ovf_irq, cap_irq, cmp_irq}, 32'h0);
        rchk(8'h14, 8'hFF, 8'hFC);
        rchk(8'h10, 8'hFF, 8'h00);
        $display("reset done");
        results();
    end
endmodule // testbench

`default_nettype wire
